// [verilog/bpc_consts.vh]
// Purpose: constants for the 10GBASE-R PCS test, signal-detect and FEC control block
// Assumes: word-indexed register port, 32-bit data
// Notes: offsets are register indices on the plain register port
`ifndef BPC_CONSTS_VH
`define BPC_CONSTS_VH
// ==========================================
// Register indices
`define BPC_A_SD_CFG 5'h00
`define BPC_A_PCS_CFG 5'h01
`define BPC_A_TEST_CFG 5'h02
`define BPC_A_SEED_A_UP 5'h03
`define BPC_A_SEED_A_LO 5'h04
`define BPC_A_SEED_B_UP 5'h05
`define BPC_A_SEED_B_LO 5'h06
`define BPC_A_TXPAT_UP 5'h07
`define BPC_A_TXPAT_LO 5'h08
`define BPC_A_RXPAT_UP 5'h09
`define BPC_A_RXPAT_LO 5'h0A
`define BPC_A_STATUS 5'h0B
`define BPC_A_ERR_CNT 5'h0C
`define BPC_A_WAKE_CNT 5'h0D
`define BPC_A_FEC_CFG 5'h0E
`define BPC_A_FEC_STICKY 5'h0F
`define BPC_A_CORR_LIM 5'h10
`define BPC_A_UNCORR_LIM 5'h11
`define BPC_A_CORR_CNT 5'h12
`define BPC_A_UNCORR_CNT 5'h13
// ==========================================
// Field positions
`define BPC_LOSS_OF_SIGNAL_REACT_ON 0
`define BPC_SIGNAL_DETECT_POLARITY 1
`define BPC_SIGNAL_DETECT_SOURCE 2
`define BPC_CFG_LOOP 0
`define BPC_CFG_TXTEST 1
`define BPC_CFG_RXTEST 2
`define BPC_TC_TXSEL_LO 0
`define BPC_TC_RXSEL_LO 2
`define BPC_TC_SQPW_LO 4
`define BPC_TC_TXINV 8
`define BPC_TC_RXINV 9
`define BPC_FC_ENA 0
`define BPC_FC_TXFLIP 1
`define BPC_FC_RXFLIP 2
`define BPC_FC_ERRIND 3
`define BPC_FC_RSTCNT 4
`define BPC_ST_LOCK 0
`define BPC_ST_CORR 1
`define BPC_ST_UNCORR 2
// ==========================================
// Pattern choices and reset values
`define BPC_PAT_SQUARE 2'h0
`define BPC_PAT_PSEUDO 2'h1
`define BPC_PAT_PRBS31 2'h2
`define BPC_PAT_USER 2'h3
`define BPC_SQPW_RST 4'h4
`define BPC_LIM_RST 32'hFFFFFFFF
`define BPC_SEED_UP_W 26
`endif

// [verilog/bpc_ctrl.v]
// Purpose: signal-detect, loopback, test pattern, low power idle and FEC control/status
// Assumes: one 40 MHz clock; pattern datapath supplies match/error events on REF_CLK
// Notes: register port gives read data in the cycle after the read strobe;
//   sticky flags are write-one-to-clear and a coincident event wins;
//   all counters saturate instead of wrapping, so a stuck source stays visible;
//   signal-detect pins pass three samplers, so a change costs three to four cycles
//
// Our own choices: the strobed register port and the placing of the registers.
`include "bpc_consts.vh"

// ==========================================
module bpc_ctrl (
	// Clock and reset
	input wire REF_CLK,
	input wire SYS_RST,
	// Register port
	input wire [4:0] REG_ADDR,
	input wire [31:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [31:0] REG_RDATA,
	// Signal detect inputs
	input wire PMA_SIGNAL_DETECT,
	input wire GPIO_SIGNAL_DETECT,
	// Receive path control
	output reg RX_FSM_RESTART,
	output reg RX_FRAME_ACCEPT,
	output reg TX_TO_RX_LOOPBACK_ON,
	// Test pattern generator and checker configuration
	output reg TEST_MODE_ON,
	output reg [1:0] GENERATOR_PATTERN_CHOICE,
	output reg [1:0] CHECKER_PATTERN_CHOICE,
	output reg [3:0] SQUARE_WAVE_PERIOD,
	output reg GENERATOR_INVERSION_OFF,
	output reg CHECKER_INVERSION_OFF,
	output reg SCRAMBLER_SEED_LOAD,
	output reg [57:0] SEED_A,
	output reg [57:0] SEED_B,
	output reg [63:0] TX_PATTERN,
	output reg [63:0] RX_PATTERN,
	// Checker events
	input wire PATTERN_MATCH,
	input wire PATTERN_ERROR,
	// Low power idle events
	input wire LOW_POWER_IDLE_STATE,
	input wire WAKE_ERROR,
	// FEC control and events
	output reg FORWARD_ERROR_CORRECTION_ON,
	output reg FEC_TX_DATA_FLIP,
	output reg FEC_RX_DATA_FLIP,
	output reg FEC_ERROR_INDICATION,
	input wire FEC_FRAME_LOCK,
	input wire FEC_CORRECTED_BLOCK,
	input wire FEC_UNCORRECTED_BLOCK
);

	// ==========================================
	// Registers
	// Signal-detect, PCS and test configuration
	reg [2:0] sd_cfg;
	reg [2:0] pcs_cfg;
	reg [9:0] test_cfg;

	// Seeds and data patterns, each kept as two words
	reg [25:0] seed_a_upper;
	reg [31:0] seed_a_lower;
	reg [25:0] seed_b_upper;
	reg [31:0] seed_b_lower;
	reg [31:0] transmit_pattern_upper;
	reg [31:0] transmit_pattern_lower;
	reg [31:0] receive_pattern_upper;
	reg [31:0] receive_pattern_lower;

	// Checker and low power idle counters
	reg [31:0] pattern_error_counter;
	reg [31:0] wake_error_counter;

	// FEC configuration, flags, limits and counters
	reg [4:0] fec_cfg;
	reg [2:0] fec_sticky;
	reg [31:0] corrected_limit;
	reg [31:0] uncorrected_limit;
	reg [31:0] corrected_block_counter;
	reg [31:0] uncorrected_block_counter;

	// Edge history and status copies
	reg rst_cnt_armed;
	reg prev_lock;
	reg prev_sd_present;
	reg pattern_match_flag;
	reg low_power_idle_state;

	// Three-stage samplers for pins from outside the clock domain
	reg [2:0] pma_sync;
	reg [2:0] gpio_sync;
	reg pma_level;
	reg gpio_level;

	// Write strobes for registers whose writes act beyond plain storage
	wire wr_fec = REG_WR && (REG_ADDR == `BPC_A_FEC_CFG);
	wire wr_sticky = REG_WR && (REG_ADDR == `BPC_A_FEC_STICKY);
	wire wr_errcnt = REG_WR && (REG_ADDR == `BPC_A_ERR_CNT);
	wire wr_wake = REG_WR && (REG_ADDR == `BPC_A_WAKE_CNT);

	// Saturating increment, used by every counter
	function [31:0] bpc_inc;
		input [31:0] v;
		begin
			bpc_inc = (v == 32'hFFFFFFFF) ? v : v + 32'h00000001;
		end
	endfunction

	// Next value of a block counter: a clear beats a coincident event
	function [31:0] bpc_step;
		input clear;
		input hit;
		input [31:0] v;
		begin
			if (clear)
				bpc_step = 32'h0;
			else if (hit)
				bpc_step = bpc_inc(v);
			else
				bpc_step = v;
		end
	endfunction

	// Threshold crossing: at or below the limit before, above it after
	function bpc_cross;
		input [31:0] prev_cnt;
		input [31:0] next_cnt;
		input [31:0] limit;
		begin
			bpc_cross = (next_cnt > limit) && (prev_cnt <= limit);
		end
	endfunction

	// ==========================================
	// Signal detect
	wire loss_of_signal_react_on = sd_cfg[`BPC_LOSS_OF_SIGNAL_REACT_ON];
	wire signal_detect_polarity = sd_cfg[`BPC_SIGNAL_DETECT_POLARITY];
	wire signal_detect_source = sd_cfg[`BPC_SIGNAL_DETECT_SOURCE];
	wire raw_sd = signal_detect_source ? gpio_level : pma_level;
	wire sd_present = (raw_sd == signal_detect_polarity);
	wire sd_lost = loss_of_signal_react_on && !sd_present;

	// Sample pins; a change counts once stages two and three agree
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pma_sync <= 3'h0;
			gpio_sync <= 3'h0;
			pma_level <= 1'b0;
			gpio_level <= 1'b0;
		end else begin
			pma_sync <= {pma_sync[1:0], PMA_SIGNAL_DETECT};
			gpio_sync <= {gpio_sync[1:0], GPIO_SIGNAL_DETECT};
			if (pma_sync[1] == pma_sync[2])
				pma_level <= pma_sync[2];
			if (gpio_sync[1] == gpio_sync[2])
				gpio_level <= gpio_sync[2];
		end
	end

	// Receiver restart pulse on signal loss, frame gate held while lost.
	// The restart is an edge and the gate a level: a signal already gone
	// when the reaction is enabled stops frames without a restart pulse.
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			prev_sd_present <= 1'b1;
			RX_FSM_RESTART <= 1'b0;
			RX_FRAME_ACCEPT <= 1'b1;
		end else begin
			prev_sd_present <= sd_present;
			RX_FSM_RESTART <= loss_of_signal_react_on && prev_sd_present && !sd_present;
			RX_FRAME_ACCEPT <= !sd_lost;
		end
	end

	// ==========================================
	// Configuration writes
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sd_cfg <= 3'h0;
			pcs_cfg <= 3'h0;
			test_cfg <= {2'h0, `BPC_SQPW_RST, 4'h0};
			seed_a_upper <= 26'h0;
			seed_a_lower <= 32'h0;
			seed_b_upper <= 26'h0;
			seed_b_lower <= 32'h0;
			transmit_pattern_upper <= 32'h0;
			transmit_pattern_lower <= 32'h0;
			receive_pattern_upper <= 32'h0;
			receive_pattern_lower <= 32'h0;
			fec_cfg <= 5'h0;
			corrected_limit <= `BPC_LIM_RST;
			uncorrected_limit <= `BPC_LIM_RST;
		end else if (REG_WR) begin
			case (REG_ADDR)
				`BPC_A_SD_CFG: sd_cfg <= REG_WDATA[2:0];
				`BPC_A_PCS_CFG: pcs_cfg <= REG_WDATA[2:0];
				`BPC_A_TEST_CFG: test_cfg <= REG_WDATA[9:0];
				`BPC_A_SEED_A_UP: seed_a_upper <= REG_WDATA[25:0];
				`BPC_A_SEED_A_LO: seed_a_lower <= REG_WDATA;
				`BPC_A_SEED_B_UP: seed_b_upper <= REG_WDATA[25:0];
				`BPC_A_SEED_B_LO: seed_b_lower <= REG_WDATA;
				`BPC_A_TXPAT_UP: transmit_pattern_upper <= REG_WDATA;
				`BPC_A_TXPAT_LO: transmit_pattern_lower <= REG_WDATA;
				`BPC_A_RXPAT_UP: receive_pattern_upper <= REG_WDATA;
				`BPC_A_RXPAT_LO: receive_pattern_lower <= REG_WDATA;
				`BPC_A_FEC_CFG: fec_cfg <= REG_WDATA[4:0];
				`BPC_A_CORR_LIM: corrected_limit <= REG_WDATA;
				`BPC_A_UNCORR_LIM: uncorrected_limit <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Registered control outputs to the datapath
	wire test_on = pcs_cfg[`BPC_CFG_TXTEST] && pcs_cfg[`BPC_CFG_RXTEST];
	wire [1:0] gen_sel = test_cfg[`BPC_TC_TXSEL_LO +: 2];
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			TX_TO_RX_LOOPBACK_ON <= 1'b0;
			TEST_MODE_ON <= 1'b0;
			GENERATOR_PATTERN_CHOICE <= `BPC_PAT_SQUARE;
			CHECKER_PATTERN_CHOICE <= `BPC_PAT_SQUARE;
			SQUARE_WAVE_PERIOD <= `BPC_SQPW_RST;
			GENERATOR_INVERSION_OFF <= 1'b0;
			CHECKER_INVERSION_OFF <= 1'b0;
			SCRAMBLER_SEED_LOAD <= 1'b0;
			SEED_A <= 58'h0;
			SEED_B <= 58'h0;
			TX_PATTERN <= 64'h0;
			RX_PATTERN <= 64'h0;
			FORWARD_ERROR_CORRECTION_ON <= 1'b0;
			FEC_TX_DATA_FLIP <= 1'b0;
			FEC_RX_DATA_FLIP <= 1'b0;
			FEC_ERROR_INDICATION <= 1'b0;
		end else begin
			TX_TO_RX_LOOPBACK_ON <= pcs_cfg[`BPC_CFG_LOOP];
			TEST_MODE_ON <= test_on;
			GENERATOR_PATTERN_CHOICE <= gen_sel;
			CHECKER_PATTERN_CHOICE <= test_cfg[`BPC_TC_RXSEL_LO +: 2];
			SQUARE_WAVE_PERIOD <= test_cfg[`BPC_TC_SQPW_LO +: 4];
			GENERATOR_INVERSION_OFF <= test_cfg[`BPC_TC_TXINV];
			CHECKER_INVERSION_OFF <= test_cfg[`BPC_TC_RXINV];
			// Seeding in user mode would cause errors at every 128-block window
			SCRAMBLER_SEED_LOAD <= test_on && (gen_sel != `BPC_PAT_USER);
			SEED_A <= {seed_a_upper, seed_a_lower};
			SEED_B <= {seed_b_upper, seed_b_lower};
			TX_PATTERN <= {transmit_pattern_upper, transmit_pattern_lower};
			RX_PATTERN <= {receive_pattern_upper, receive_pattern_lower};
			FORWARD_ERROR_CORRECTION_ON <= fec_cfg[`BPC_FC_ENA];
			FEC_TX_DATA_FLIP <= fec_cfg[`BPC_FC_TXFLIP];
			FEC_RX_DATA_FLIP <= fec_cfg[`BPC_FC_RXFLIP];
			FEC_ERROR_INDICATION <= fec_cfg[`BPC_FC_ERRIND];
		end
	end

	// ==========================================
	// Test checker and low power idle status
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pattern_match_flag <= 1'b0;
			pattern_error_counter <= 32'h0;
			low_power_idle_state <= 1'b0;
			wake_error_counter <= 32'h0;
		end else begin
			pattern_match_flag <= test_on && PATTERN_MATCH;
			low_power_idle_state <= LOW_POWER_IDLE_STATE;
			// Error in the clearing cycle still counts as one
			if (wr_errcnt && REG_WDATA == 32'h0)
				pattern_error_counter <= {31'h0, test_on && PATTERN_ERROR};
			else if (test_on && PATTERN_ERROR)
				pattern_error_counter <= bpc_inc(pattern_error_counter);
			if (wr_wake && REG_WDATA == 32'h0)
				wake_error_counter <= {31'h0, WAKE_ERROR};
			else if (WAKE_ERROR)
				wake_error_counter <= bpc_inc(wake_error_counter);
		end
	end

	// ==========================================
	// FEC counters, thresholds and sticky flags
	// Clear happens on the 1-to-0 write of the reset-counters bit
	wire cnt_clear = wr_fec && rst_cnt_armed && !REG_WDATA[`BPC_FC_RSTCNT];
	wire [31:0] corr_next = bpc_step(cnt_clear, FEC_CORRECTED_BLOCK, corrected_block_counter);
	wire [31:0] uncorr_next = bpc_step(cnt_clear, FEC_UNCORRECTED_BLOCK, uncorrected_block_counter);
	// Lock loss is the falling edge of the lock level; prev_lock resets low
	// so a link still unlocked after reset raises no false flag
	wire lock_lost = prev_lock && !FEC_FRAME_LOCK;
	// Judged against the next count so the flag rises in the crossing cycle
	wire corr_cross = bpc_cross(corrected_block_counter, corr_next, corrected_limit);
	wire uncorr_cross = bpc_cross(uncorrected_block_counter, uncorr_next, uncorrected_limit);
	wire [2:0] sticky_set = {uncorr_cross, corr_cross, lock_lost};
	wire [2:0] sticky_clr = wr_sticky ? REG_WDATA[2:0] : 3'h0;

	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rst_cnt_armed <= 1'b0;
			prev_lock <= 1'b0;
			corrected_block_counter <= 32'h0;
			uncorrected_block_counter <= 32'h0;
			fec_sticky <= 3'h0;
		end else begin
			if (wr_fec)
				rst_cnt_armed <= REG_WDATA[`BPC_FC_RSTCNT];
			prev_lock <= FEC_FRAME_LOCK;
			corrected_block_counter <= corr_next;
			uncorrected_block_counter <= uncorr_next;
			// Write one to clear; a new event in the same cycle wins
			fec_sticky <= (fec_sticky & ~sticky_clr) | sticky_set;
		end
	end

	// ==========================================
	// Register read, data valid the cycle after the strobe
	// Lock and signal presence are read live; match and idle come from copies
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			REG_RDATA <= 32'h0;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`BPC_A_SD_CFG: REG_RDATA <= {29'h0, sd_cfg};
				`BPC_A_PCS_CFG: REG_RDATA <= {29'h0, pcs_cfg};
				`BPC_A_TEST_CFG: REG_RDATA <= {22'h0, test_cfg};
				`BPC_A_SEED_A_UP: REG_RDATA <= {6'h0, seed_a_upper};
				`BPC_A_SEED_A_LO: REG_RDATA <= seed_a_lower;
				`BPC_A_SEED_B_UP: REG_RDATA <= {6'h0, seed_b_upper};
				`BPC_A_SEED_B_LO: REG_RDATA <= seed_b_lower;
				`BPC_A_TXPAT_UP: REG_RDATA <= transmit_pattern_upper;
				`BPC_A_TXPAT_LO: REG_RDATA <= transmit_pattern_lower;
				`BPC_A_RXPAT_UP: REG_RDATA <= receive_pattern_upper;
				`BPC_A_RXPAT_LO: REG_RDATA <= receive_pattern_lower;
				`BPC_A_STATUS: REG_RDATA <= {28'h0, sd_present, FEC_FRAME_LOCK, low_power_idle_state,
					pattern_match_flag};
				`BPC_A_ERR_CNT: REG_RDATA <= pattern_error_counter;
				`BPC_A_WAKE_CNT: REG_RDATA <= wake_error_counter;
				`BPC_A_FEC_CFG: REG_RDATA <= {27'h0, fec_cfg};
				`BPC_A_FEC_STICKY: REG_RDATA <= {29'h0, fec_sticky};
				`BPC_A_CORR_LIM: REG_RDATA <= corrected_limit;
				`BPC_A_UNCORR_LIM: REG_RDATA <= uncorrected_limit;
				`BPC_A_CORR_CNT: REG_RDATA <= corrected_block_counter;
				`BPC_A_UNCORR_CNT: REG_RDATA <= uncorrected_block_counter;
				default: REG_RDATA <= 32'h0; // Unmapped reads as zero
			endcase
		end else begin
			REG_RDATA <= 32'h0;
		end
	end

endmodule

// [test/bpc_ctrl_sva.sv]
// Purpose: port assertions for the PCS control block
// Assumes: one clock, asynchronous active-high reset
// Notes: bound into bpc_ctrl from the bench top
module bpc_ctrl_sva (
	// Clock, reset and write side of the register port
	input logic REF_CLK,
	input logic SYS_RST,
	input logic [4:0] REG_ADDR,
	input logic [31:0] REG_WDATA,
	input logic REG_WR,
	// Watched outputs
	input logic RX_FSM_RESTART,
	input logic RX_FRAME_ACCEPT,
	input logic TX_TO_RX_LOOPBACK_ON,
	input logic TEST_MODE_ON,
	input logic [1:0] GENERATOR_PATTERN_CHOICE,
	input logic SCRAMBLER_SEED_LOAD,
	input logic FEC_ERROR_INDICATION
);
	timeunit 1ns;
	timeprecision 100ps;
	logic react;
	wire sd_wr = REG_WR && REG_ADDR == 5'h00;
	wire cfg_wr = REG_WR && REG_ADDR == 5'h01;
	wire tc_wr = REG_WR && REG_ADDR == 5'h02;
	wire fc_wr = REG_WR && REG_ADDR == 5'h0E;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	// ====
	// Copy of the reaction bit; quiet periods are judged against it
	always @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			react <= 1'b0;
		else if (sd_wr)
			react <= REG_WDATA[0];
	end
	// ====
	// Configuration outputs are seen two edges after the write: register, then output stage
	loop_follow_a: assert property (cfg_wr |-> ##2 TX_TO_RX_LOOPBACK_ON == $past(REG_WDATA[0], 2))
		else $error("loopback enable wrong");
	test_mode_a: assert property (cfg_wr |-> ##2 TEST_MODE_ON == &$past(REG_WDATA[2:1], 2))
		else $error("test mode wrong");
	gen_sel_a: assert property (tc_wr |-> ##2 GENERATOR_PATTERN_CHOICE == $past(REG_WDATA[1:0], 2))
		else $error("generator choice wrong");
	seed_load_a: assert property (SCRAMBLER_SEED_LOAD == (TEST_MODE_ON && GENERATOR_PATTERN_CHOICE != 2'h3))
		else $error("seed load wrong");
	fec_mark_a: assert property (fc_wr |-> ##2 FEC_ERROR_INDICATION == $past(REG_WDATA[3], 2))
		else $error("error marking wrong");
	// Loss of signal: one restart pulse, frames stop
	restart_stop_a: assert property (RX_FSM_RESTART |-> ##[0:1] !RX_FRAME_ACCEPT)
		else $error("frames still accepted");
	restart_pulse_a: assert property (RX_FSM_RESTART |=> !RX_FSM_RESTART)
		else $error("restart longer than one cycle");
	// Two cycles of grace: the output lags the stored bit
	quiet_off_a: assert property (!react && !$past(react) && !$past(react, 2) |-> !RX_FSM_RESTART && RX_FRAME_ACCEPT)
		else $error("reaction while disabled");
	cover property (RX_FSM_RESTART);
	cover property (TEST_MODE_ON && SCRAMBLER_SEED_LOAD);
	cover property (TEST_MODE_ON && GENERATOR_PATTERN_CHOICE == 2'h3);
endmodule

// [test/bpc_pma_model.sv]
// Purpose: far side: serializer, optical receiver, FEC and checker events
// Assumes: events are one cycle each, launched right after a rising edge
// Notes: the bench commands levels and event lines through the command ports
module bpc_pma_model (
	// Commands from the bench
	input logic [4:0] lvl_set,
	input logic [3:0] ev_set,
	// Levels towards the block
	output logic pma_sd,
	output logic gpio_sd,
	output logic fec_lock,
	output logic lpi,
	output logic match,
	// Events: 0 pattern error, 1 wake error, 2 corrected, 3 uncorrected
	output logic [3:0] ev
);
	timeunit 1ns;
	timeprecision 100ps;
	// ====
	// Levels follow the command at once; an unlocked FEC reports no blocks
	always_comb begin
		{pma_sd, gpio_sd, fec_lock, lpi, match} = lvl_set;
		ev = {ev_set[3:2] & {2{lvl_set[2]}}, ev_set[1:0]};
	end
endmodule

// [test/baser_pcs_test_sd_fec_ctrl_test.sv]
// Purpose: self-checking bench for the PCS control block
// Assumes: 40 MHz clock, reset held five cycles
// Notes: far-side levels and events come from the PMA model
module baser_pcs_test_sd_fec_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [4:0] far_lvl = 5'h1C;
	logic [3:0] far_ev = 4'h0;
	wire [31:0] rdata;
	wire rs, acc, loop, tm, ig, ic, sl, fe, tf, rf, ei, psd, gsd, lk, lpi, mt;
	wire [1:0] gs, cs;
	wire [3:0] sq, ev;
	wire [57:0] sa, sb;
	wire [63:0] tp, rp;
	int err_total = 0;
	int tests_run = 0;
	int n_rst = 0;
	int k;
	// ====
	// Clock; restart pulses counted on the falling edge where settled
	always #12.5 clk = ~clk;
	always @(negedge clk)
		if (rs === 1'b1)
			n_rst++;
	bpc_ctrl uut (.REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s),
		.REG_RDATA(rdata), .PMA_SIGNAL_DETECT(psd), .GPIO_SIGNAL_DETECT(gsd), .RX_FSM_RESTART(rs),
		.RX_FRAME_ACCEPT(acc), .TX_TO_RX_LOOPBACK_ON(loop), .TEST_MODE_ON(tm), .GENERATOR_PATTERN_CHOICE(gs),
		.CHECKER_PATTERN_CHOICE(cs), .SQUARE_WAVE_PERIOD(sq), .GENERATOR_INVERSION_OFF(ig),
		.CHECKER_INVERSION_OFF(ic), .SCRAMBLER_SEED_LOAD(sl), .SEED_A(sa), .SEED_B(sb), .TX_PATTERN(tp),
		.RX_PATTERN(rp), .PATTERN_MATCH(mt), .PATTERN_ERROR(ev[0]), .LOW_POWER_IDLE_STATE(lpi),
		.WAKE_ERROR(ev[1]), .FORWARD_ERROR_CORRECTION_ON(fe), .FEC_TX_DATA_FLIP(tf), .FEC_RX_DATA_FLIP(rf),
		.FEC_ERROR_INDICATION(ei), .FEC_FRAME_LOCK(lk), .FEC_CORRECTED_BLOCK(ev[2]), .FEC_UNCORRECTED_BLOCK(ev[3]));
	bpc_pma_model pm (.lvl_set(far_lvl), .ev_set(far_ev), .pma_sd(psd), .gpio_sd(gsd), .fec_lock(lk), .lpi(lpi),
		.match(mt), .ev(ev));
	// ====
	// Bus helpers; checks run 1 ns after an edge so outputs have landed
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task wr(input logic [4:0] a, input logic [31:0] v);
		wr_s <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr_s <= 1'b0;
		tick(1);
	endtask
	task rchk(input logic [4:0] a, input logic [31:0] e);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk(rdata, e);
	endtask
	// Far-side levels change together, held at least one cycle
	task lvl(input logic [4:0] v);
		far_lvl <= v;
		@(posedge clk);
	endtask
	// Back-to-back events on one line, then a quiet cycle
	task burst(input int i, input int n);
		repeat (n) begin
			far_ev[i] <= 1'b1;
			@(posedge clk);
		end
		far_ev[i] <= 1'b0;
		@(posedge clk);
	endtask
	task report_and_stop;
		$display("Mismatches %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ====
	// Scenarios
	task t_sigdet;
		chk({acc, sq}, 5'h14);
		rchk(5'h10, 32'hFFFFFFFF);
		wr(5'h1F, 32'hFFFFFFFF);
		rchk(5'h1F, 32'h0);
		wr(5'h00, 32'h3);
		n_rst = 0;
		lvl(5'h0C);
		for (k = 0; k < 8 && n_rst == 0; k++)
			@(posedge clk);
		tick(2);
		chk({n_rst[1:0], acc}, 3'h2);
		wr(5'h00, 32'h1);
		tick(5);
		chk(acc, 1'b1);
		wr(5'h00, 32'h7);
		tick(5);
		chk(acc, 1'b1);
		lvl(5'h14);
		tick(5);
		chk(acc, 1'b0);
		n_rst = 0;
		wr(5'h00, 32'h6);
		lvl(5'h0C);
		tick(5);
		lvl(5'h14);
		tick(5);
		chk({n_rst[1:0], acc}, 3'h1);
		lvl(5'h1C);
	endtask
	task t_pattern;
		for (k = 0; k < 8; k++) begin
			wr(5'h01, 32'(k));
			chk({loop, tm}, {k[0], k[1] & k[2]});
		end
		for (k = 0; k < 4; k++) begin
			wr(5'h02, {22'h0, k[1:0], 4'(k * 5), 2'(3 - k), k[1:0]});
			chk({cs, gs, sq}, {2'(3 - k), k[1:0], 4'(k * 5)});
			chk({ic, ig, sl}, {k[1:0], k != 3});
		end
		for (k = 3; k < 11; k++)
			wr(5'(k), 32'hFFFF0000 | k);
		chk(sa, {26'h3FF0003, 32'hFFFF0004});
		chk(sb, {26'h3FF0005, 32'hFFFF0006});
		chk(tp, 64'hFFFF0007FFFF0008);
		chk(rp, 64'hFFFF0009FFFF000A);
		rchk(5'h05, 32'h03FF0005);
	endtask
	task t_status;
		lvl(5'h1D);
		burst(0, 5);
		rchk(5'h0B, 32'hD);
		rchk(5'h0C, 32'h5);
		wr(5'h0C, 32'h7);
		rchk(5'h0C, 32'h5);
		wr(5'h0C, 32'h0);
		rchk(5'h0C, 32'h0);
		lvl(5'h1E);
		burst(1, 3);
		rchk(5'h0B, 32'hE);
		rchk(5'h0D, 32'h3);
		wr(5'h0D, 32'h0);
		rchk(5'h0D, 32'h0);
		lvl(5'h1C);
	endtask
	task t_fec;
		wr(5'h0F, 32'h7);
		wr(5'h0E, 32'hF);
		chk({ei, rf, tf, fe}, 4'hF);
		wr(5'h10, 32'h2);
		wr(5'h11, 32'h1);
		burst(2, 3);
		burst(3, 1);
		rchk(5'h12, 32'h3);
		rchk(5'h0F, 32'h2);
		burst(3, 1);
		rchk(5'h0F, 32'h6);
		lvl(5'h18);
		tick(4);
		lvl(5'h1C);
		tick(4);
		wr(5'h0F, 32'h6);
		rchk(5'h0F, 32'h1);
		wr(5'h0E, 32'h1F);
		wr(5'h0E, 32'hF);
		rchk(5'h12, 32'h0);
		rchk(5'h13, 32'h0);
	endtask
	// ====
	// Main sequence and watchdog share one ending
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		t_sigdet;
		t_pattern;
		t_status;
		t_fec;
		report_and_stop;
	end
	initial begin
		#100us;
		err_total++;
		report_and_stop;
	end
endmodule
bind bpc_ctrl bpc_ctrl_sva chk_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .RX_FSM_RESTART(RX_FSM_RESTART), .RX_FRAME_ACCEPT(RX_FRAME_ACCEPT),
	.TX_TO_RX_LOOPBACK_ON(TX_TO_RX_LOOPBACK_ON), .TEST_MODE_ON(TEST_MODE_ON),
	.GENERATOR_PATTERN_CHOICE(GENERATOR_PATTERN_CHOICE), .SCRAMBLER_SEED_LOAD(SCRAMBLER_SEED_LOAD),
	.FEC_ERROR_INDICATION(FEC_ERROR_INDICATION));
